// File: design/playback_mix_defines.svh
`ifndef PLAYBACK_MIX_DEFINES_SVH
`define PLAYBACK_MIX_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_OFFSET_MIX_CONFIG 16'hfec1
`define IDX_OFFSET_LEFT_LOW 16'hfec2
`define IDX_OFFSET_LEFT_HIGH 16'hfec3
`define IDX_OFFSET_RIGHT_LOW 16'hfec4
`define IDX_OFFSET_RIGHT_HIGH 16'hfec5
`define IDX_RESAMPLER_CONFIG 16'hfec6
`define IDX_RESAMPLER_LEFT_LOW 16'hfec7
`define IDX_RESAMPLER_LEFT_HIGH 16'hfed8
`define IDX_RESAMPLER_RIGHT_LOW 16'hfed9
`define IDX_RESAMPLER_RIGHT_HIGH 16'hfeda

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_RATE_MSB 11
`define CFG_ENABLE_BIT 12
`define OFF_FULL_BIT 13
`define OFF_URUN_BIT 14
`define SRC_LFULL_BIT 13
`define SRC_RFULL_BIT 14
`define SRC_ORUN_BIT 15

// ----------------------------------------------------------------
// reset values, counts and saturation limits
// ----------------------------------------------------------------
`define REG_RESET_VALUE 16'h0000
`define SRC_START_INPUTS 5'h13
`define MIX_MAX_POS 20'h7ffff
`define MIX_MAX_NEG 20'h80000

`endif

// File: design/playback_mix_pkg.sv
package playback_mix_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_phase_e;

    typedef enum logic [3:0] {
        SEL_OFF_CFG = 4'h0,
        SEL_OFF_LLO = 4'h1,
        SEL_OFF_LHI = 4'h2,
        SEL_OFF_RLO = 4'h3,
        SEL_OFF_RHI = 4'h4,
        SEL_SRC_CFG = 4'h5,
        SEL_SRC_LLO = 4'h6,
        SEL_SRC_LHI = 4'h7,
        SEL_SRC_RLO = 4'h8,
        SEL_SRC_RHI = 4'h9,
        SEL_NONE = 4'hf
    } reg_sel_e;

    typedef struct packed {
        bus_phase_e busPh;
        logic waitReq;
        logic [31:0] rdata;
        logic [11:0] offRate;
        logic offEn;
        logic offFull;
        logic offUrun;
        logic offWrL;
        logic offWrR;
        logic [3:0] offLLo;
        logic [15:0] offLHi;
        logic [3:0] offRLo;
        logic [15:0] offRHi;
        logic [11:0] offCnt;
        logic [19:0] holdL;
        logic [19:0] holdR;
        logic [19:0] mixL;
        logic [19:0] mixR;
        logic offIrq;
        logic [11:0] srcRate;
        logic srcEn;
        logic srcOrun;
        logic srcLFull;
        logic srcRFull;
        logic [7:0] srcLLo;
        logic [15:0] srcLHi;
        logic [7:0] srcRLo;
        logic [15:0] srcRHi;
        logic [12:0] srcCnt;
        logic [23:0] capL;
        logic [23:0] capR;
        logic [4:0] startCnt;
        logic srcIrq;
    } mix_state_s;

endpackage : playback_mix_pkg

// File: design/playback_offset_mixer_and_src.sv
// What this block does
// - adds a secondary stereo offset stream to main playback output before conversion
// - offset config bit 12 enables mixing; cleared, the offset module is idle
// - offset full flag bit 13 sets on left+right data writes, clears on fetch
// - offset underrun flag bit 14 sets when a fetch finds full flag clear
// - offset rate bits 11:0 give fetch interval of field plus one cycles
// - offset interval counter runs on the crystal clock
// - every offset sample fetch raises an interrupt request pulse
// - offset channel is 20 bits: high register 19:4, low register bits 15:12 give 3:0
// - main plus offset sum saturates to 20-bit signed range
// - resampler resamples main input stream to a higher output rate
// - resampler applies no interpolation or anti-alias filtering
// - resampler output valid only after 19 main input samples since start
// - resampler config bit 12 enables the resampler
// - resampler overrun bit 15 sets when storing over unread data
// - left and right full flags set on store, clear on software read
// - resampler rate bits 11:0 give one output every 2*(field+1) cycles
// - every resampler store raises an interrupt request pulse
// - resampler channel is 24 bits: high register 23:8, low register 7:0
// - offset samples are held until the next fetch that finds the full flag set, no filtering
// - resampler input is taken from the samples feeding the main interpolator
`timescale 1ns/1ps
`default_nettype none
`include "playback_mix_defines.svh"

module playback_offset_mixer_and_src
    import playback_mix_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // main path, interpolator output side
    input wire logic [19:0] mainLeft,
    input wire logic [19:0] mainRight,
    // main path, interpolator input side
    input wire logic [23:0] dacLeft,
    input wire logic [23:0] dacRight,
    input wire logic dacSampleStrobe,
    // mixed output and requests
    output logic [19:0] mixLeft,
    output logic [19:0] mixRight,
    output logic offsetIrq,
    output logic resamplerIrq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic reg_sel_e regSel(input logic [17:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            unique case (a[17:2])
                `IDX_OFFSET_MIX_CONFIG: s = SEL_OFF_CFG;
                `IDX_OFFSET_LEFT_LOW: s = SEL_OFF_LLO;
                `IDX_OFFSET_LEFT_HIGH: s = SEL_OFF_LHI;
                `IDX_OFFSET_RIGHT_LOW: s = SEL_OFF_RLO;
                `IDX_OFFSET_RIGHT_HIGH: s = SEL_OFF_RHI;
                `IDX_RESAMPLER_CONFIG: s = SEL_SRC_CFG;
                `IDX_RESAMPLER_LEFT_LOW: s = SEL_SRC_LLO;
                `IDX_RESAMPLER_LEFT_HIGH: s = SEL_SRC_LHI;
                `IDX_RESAMPLER_RIGHT_LOW: s = SEL_SRC_RLO;
                `IDX_RESAMPLER_RIGHT_HIGH: s = SEL_SRC_RHI;
                default: s = SEL_NONE;
            endcase
        end
        return s;
    endfunction : regSel

    function automatic logic [19:0] satAdd(input logic [19:0] a, input logic [19:0] b);
        logic [20:0] s;
        s = {a[19], a} + {b[19], b};
        if (s[20] != s[19]) begin
            return s[20] ? `MIX_MAX_NEG : `MIX_MAX_POS;
        end
        return s[19:0];
    endfunction : satAdd

    mix_state_s st_r;
    mix_state_s st_nxt;
    reg_sel_e sel;
    logic access;
    logic wrOk;
    logic rdOk;
    logic offTick;
    logic srcTick;
    logic srcStore;
    logic dataWrDone;
    logic [15:0] rdVal;

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    always_comb begin
        sel = regSel(address);
        access = (st_r.busPh == BUS_IDLE) && (read || write);
        wrOk = access && write && (byteenable[1:0] == 2'h3);
        rdOk = access && read;
        offTick = st_r.offEn && (st_r.offCnt >= st_r.offRate);
        srcTick = st_r.srcEn && (st_r.srcCnt >= {st_r.srcRate, 1'b1});
        srcStore = srcTick && (st_r.startCnt == `SRC_START_INPUTS);
        dataWrDone = wrOk && (((sel == SEL_OFF_LHI) && (st_r.offWrR || st_r.offFull))
            || ((sel == SEL_OFF_RHI) && (st_r.offWrL || st_r.offFull)));
        unique case (sel)
            SEL_OFF_CFG: rdVal = {1'b0, st_r.offUrun, st_r.offFull, st_r.offEn, st_r.offRate};
            SEL_OFF_LLO: rdVal = {st_r.offLLo, 12'h000};
            SEL_OFF_LHI: rdVal = st_r.offLHi;
            SEL_OFF_RLO: rdVal = {st_r.offRLo, 12'h000};
            SEL_OFF_RHI: rdVal = st_r.offRHi;
            SEL_SRC_CFG: rdVal = {st_r.srcOrun, st_r.srcRFull, st_r.srcLFull, st_r.srcEn,
                st_r.srcRate};
            SEL_SRC_LLO: rdVal = {st_r.srcLLo, 8'h00};
            SEL_SRC_LHI: rdVal = st_r.srcLHi;
            SEL_SRC_RLO: rdVal = {st_r.srcRLo, 8'h00};
            SEL_SRC_RHI: rdVal = st_r.srcRHi;
            default: rdVal = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.offIrq = 1'b0;
        st_nxt.srcIrq = 1'b0;

        // bus handshake: one wait cycle, then waitrequest low for one cycle
        unique case (st_r.busPh)
            BUS_IDLE: begin
                if (read || write) begin
                    st_nxt.busPh = BUS_DONE;
                    st_nxt.waitReq = 1'b0;
                    st_nxt.rdata = read ? {16'h0000, rdVal} : 32'h0000_0000;
                end
            end
            BUS_DONE: begin
                st_nxt.busPh = BUS_IDLE;
                st_nxt.waitReq = 1'b1;
            end
        endcase

        // register writes
        if (wrOk) begin
            unique case (sel)
                SEL_OFF_CFG: begin
                    st_nxt.offRate = writedata[`CFG_RATE_MSB:0];
                    st_nxt.offEn = writedata[`CFG_ENABLE_BIT];
                    if (writedata[`OFF_URUN_BIT]) begin
                        st_nxt.offUrun = 1'b0;
                    end
                end
                SEL_OFF_LLO: st_nxt.offLLo = writedata[15:12];
                SEL_OFF_LHI: begin
                    st_nxt.offLHi = writedata[15:0];
                    st_nxt.offWrL = 1'b1;
                end
                SEL_OFF_RLO: st_nxt.offRLo = writedata[15:12];
                SEL_OFF_RHI: begin
                    st_nxt.offRHi = writedata[15:0];
                    st_nxt.offWrR = 1'b1;
                end
                SEL_SRC_CFG: begin
                    st_nxt.srcRate = writedata[`CFG_RATE_MSB:0];
                    st_nxt.srcEn = writedata[`CFG_ENABLE_BIT];
                    if (writedata[`SRC_ORUN_BIT]) begin
                        st_nxt.srcOrun = 1'b0;
                    end
                end
                SEL_SRC_LLO: st_nxt.srcLLo = writedata[15:8];
                SEL_SRC_LHI: st_nxt.srcLHi = writedata[15:0];
                SEL_SRC_RLO: st_nxt.srcRLo = writedata[15:8];
                SEL_SRC_RHI: st_nxt.srcRHi = writedata[15:0];
                default: st_nxt.offIrq = 1'b0;
            endcase
        end

        // reads of the high data words clear the full flags
        if (rdOk && (sel == SEL_SRC_LHI)) begin
            st_nxt.srcLFull = 1'b0;
        end
        if (rdOk && (sel == SEL_SRC_RHI)) begin
            st_nxt.srcRFull = 1'b0;
        end

        // offset interval counter on the crystal clock
        if (!st_r.offEn || offTick) begin
            st_nxt.offCnt = 12'h000;
        end else begin
            st_nxt.offCnt = st_r.offCnt + 12'h001;
        end

        // offset fetch: sample and hold, flags, request
        if (offTick) begin
            if (st_r.offFull) begin
                st_nxt.holdL = {st_r.offLHi, st_r.offLLo};
                st_nxt.holdR = {st_r.offRHi, st_r.offRLo};
            end else begin
                st_nxt.offUrun = 1'b1;
            end
            st_nxt.offFull = 1'b0;
            st_nxt.offIrq = 1'b1;
        end
        if (dataWrDone) begin
            st_nxt.offFull = 1'b1;
            st_nxt.offWrL = 1'b0;
            st_nxt.offWrR = 1'b0;
        end

        // mixing stage, pass-through while disabled
        if (st_r.offEn) begin
            st_nxt.mixL = satAdd(mainLeft, st_r.holdL);
            st_nxt.mixR = satAdd(mainRight, st_r.holdR);
        end else begin
            st_nxt.mixL = mainLeft;
            st_nxt.mixR = mainRight;
        end

        // resampler: capture interpolator input, count start-up samples
        if (!st_r.srcEn) begin
            st_nxt.startCnt = 5'h00;
            st_nxt.srcCnt = 13'h0000;
        end else begin
            st_nxt.srcCnt = srcTick ? 13'h0000 : st_r.srcCnt + 13'h0001;
            if (dacSampleStrobe) begin
                st_nxt.capL = dacLeft;
                st_nxt.capR = dacRight;
                if (st_r.startCnt != `SRC_START_INPUTS) begin
                    st_nxt.startCnt = st_r.startCnt + 5'h01;
                end
            end
        end

        // resampler store: latest input copied unfiltered
        if (srcStore) begin
            st_nxt.srcLHi = st_r.capL[23:8];
            st_nxt.srcLLo = st_r.capL[7:0];
            st_nxt.srcRHi = st_r.capR[23:8];
            st_nxt.srcRLo = st_r.capR[7:0];
            st_nxt.srcLFull = 1'b1;
            st_nxt.srcRFull = 1'b1;
            if (st_r.srcLFull || st_r.srcRFull) begin
                st_nxt.srcOrun = 1'b1;
            end
            st_nxt.srcIrq = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.waitReq <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata = st_r.rdata;
    assign waitrequest = st_r.waitReq;
    assign mixLeft = st_r.mixL;
    assign mixRight = st_r.mixR;
    assign offsetIrq = st_r.offIrq;
    assign resamplerIrq = st_r.srcIrq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [20:0] sumChkL;
    assign sumChkL = {mainLeft[19], mainLeft} + {st_r.holdL[19], st_r.holdL};

    a_mix_sat_pos: assert property (st_r.offEn && !sumChkL[20] && sumChkL[19]
        |=> mixLeft == `MIX_MAX_POS) else $error("positive mix did not saturate");
    a_off_full_set: assert property ($rose(st_r.offFull) |-> $past(dataWrDone))
        else $error("offset full flag rose without data writes");
    a_off_urun_set: assert property (offTick && !st_r.offFull |=> st_r.offUrun)
        else $error("underrun not flagged");
    a_off_interval: assert property (offTick
        |=> st_r.offCnt == 12'h000 && offTick == (st_r.offEn && st_r.offRate == 12'h000))
        else $error("offset interval counter did not restart");
    a_off_fetch_irq: assert property (offTick
        |=> offsetIrq && (!st_r.offFull || $past(dataWrDone)))
        else $error("fetch without request");
    a_off_disabled: assert property (!st_r.offEn |=> mixLeft == $past(mainLeft))
        else $error("disabled mixer altered main path");
    a_src_store_irq: assert property (srcStore
        |=> resamplerIrq && st_r.srcLFull && st_r.srcRFull) else $error("store without irq");
    a_src_overrun: assert property (srcStore && (st_r.srcLFull || st_r.srcRFull)
        |=> st_r.srcOrun) else $error("overrun not flagged");
    a_src_startup: assert property ($rose(resamplerIrq)
        |-> $past(st_r.startCnt) == `SRC_START_INPUTS) else $error("output before start-up");
    a_src_enable_gate: assert property (!st_r.srcEn |-> !srcTick ##1 !resamplerIrq)
        else $error("disabled resampler produced output");

    // ----------------------------------------------------------------
    // bus checks
    // ----------------------------------------------------------------
    a_bus_answer: assert property ((st_r.busPh == BUS_IDLE) && (read || write)
        |=> !waitrequest)
        else $error("bus request not answered");
    a_bus_wait_pulse: assert property (!waitrequest
        |=> waitrequest)
        else $error("waitrequest low too long");
    a_bus_rd_upper: assert property (!waitrequest
        |-> readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

    // ----------------------------------------------------------------
    // offset checks
    // ----------------------------------------------------------------
    a_off_hold_stable: assert property (!offTick
        |=> $stable(st_r.holdL) && $stable(st_r.holdR))
        else $error("offset hold changed without fetch");
    a_off_fetch_load: assert property (offTick && st_r.offFull
        |=> st_r.holdL[19:4] == $past(st_r.offLHi) && st_r.holdL[3:0] == $past(st_r.offLLo))
        else $error("fetch loaded wrong left offset");
    a_off_irq_cause: assert property (offsetIrq
        |-> $past(offTick))
        else $error("offset request without fetch");
    a_off_urun_cause: assert property ($rose(st_r.offUrun)
        |-> $past(offTick) && !$past(st_r.offFull))
        else $error("underrun without empty fetch");
    a_off_cnt_clear: assert property (!st_r.offEn
        |=> st_r.offCnt == 12'h000)
        else $error("offset counter runs while disabled");
    a_mix_sat_neg: assert property (st_r.offEn && sumChkL[20] && !sumChkL[19]
        |=> mixLeft == `MIX_MAX_NEG)
        else $error("negative mix did not saturate");

    // ----------------------------------------------------------------
    // resampler checks
    // ----------------------------------------------------------------
    a_src_store_data: assert property (srcStore
        |=> {st_r.srcLHi, st_r.srcLLo} == $past(st_r.capL)
            && {st_r.srcRHi, st_r.srcRLo} == $past(st_r.capR))
        else $error("stored sample differs from capture");
    a_src_read_clear: assert property (rdOk && (sel == SEL_SRC_LHI) && !srcStore
        |=> !st_r.srcLFull)
        else $error("left full flag not cleared by read");
    a_src_restart: assert property (srcTick
        |=> st_r.srcCnt == 13'h0000)
        else $error("resampler counter did not restart");
    a_src_irq_cause: assert property (resamplerIrq
        |-> $past(srcStore))
        else $error("resampler request without store");
    a_src_orun_cause: assert property ($rose(st_r.srcOrun)
        |-> $past(srcStore))
        else $error("overrun without store");
    a_src_start_clear: assert property (!st_r.srcEn
        |=> st_r.startCnt == 5'h00)
        else $error("start-up count kept while disabled");

    c_off_fetch: cover property (offTick && st_r.offFull);
    c_off_urun: cover property (offTick && !st_r.offFull);
    c_src_store: cover property (srcStore);
    c_src_orun: cover property (srcStore && st_r.srcLFull);
    c_bus_src_read: cover property (rdOk && (sel == SEL_SRC_LHI));

endmodule : playback_offset_mixer_and_src

`default_nettype wire

// File: dv/dac_path_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// main playback path model
// ----------------------------------------
module dac_path_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench control
    input wire logic [19:0] levelL,
    input wire logic [19:0] levelR,
    input wire logic [7:0] gap,
    // main path
    output logic [19:0] mainLeft,
    output logic [19:0] mainRight,
    output logic [23:0] dacLeft,
    output logic [23:0] dacRight,
    output logic dacSampleStrobe
);
    logic [7:0] cnt;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {mainLeft, mainRight, dacLeft, dacRight, dacSampleStrobe, cnt} <= '0;
        end else begin
            mainLeft <= levelL;
            mainRight <= levelR;
            dacSampleStrobe <= 1'b0;
            cnt <= cnt + 8'h1;
            if (gap != 8'h0 && cnt >= gap - 8'h1) begin
                cnt <= 8'h0;
                dacSampleStrobe <= 1'b1;
                dacLeft <= dacLeft + 24'h3a5c71;
                dacRight <= dacRight - 24'h1b9e2d;
            end
        end
    end
endmodule : dac_path_model
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "playback_mix_defines.svh"
module testbench
    import playback_mix_pkg::*;
;
    logic sys_clk, rst, read, write, waitrequest, dacSampleStrobe, offsetIrq, resamplerIrq;
    logic [17:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, seed;
    logic [19:0] mainLeft, mainRight, mixLeft, mixRight, levelL, levelR, m, o;
    logic [23:0] dacLeft, dacRight;
    logic [7:0] gap;
    logic [11:0] rate;
    logic [15:0] v, idx[10], msk[10];
    int num_errors, samples_checked, cyc, strobes, t0, t1;
    // ----------------------------------------
    // instances and clock
    // ----------------------------------------
    playback_offset_mixer_and_src i_playback_offset_mixer_and_src (.sys_clk(sys_clk),
        .rst(rst), .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .mainLeft(mainLeft), .mainRight(mainRight), .dacLeft(dacLeft), .dacRight(dacRight),
        .dacSampleStrobe(dacSampleStrobe), .mixLeft(mixLeft), .mixRight(mixRight),
        .offsetIrq(offsetIrq), .resamplerIrq(resamplerIrq));
    dac_path_model i_dac_path_model (.sys_clk(sys_clk), .rst(rst), .levelL(levelL),
        .levelR(levelR), .gap(gap), .mainLeft(mainLeft), .mainRight(mainRight),
        .dacLeft(dacLeft), .dacRight(dacRight), .dacSampleStrobe(dacSampleStrobe));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (dacSampleStrobe === 1'b1) strobes <= strobes + 1;
        if (resamplerIrq === 1'b1) begin
            chkCnt("inputs before store", 1, int'(strobes >= 19));
        end
        if (cyc == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [19:0] sat(input logic [19:0] a, input logic [19:0] b);
        logic [20:0] s;
        s = {a[19], a} + {b[19], b};
        if (s[20] != s[19]) return s[20] ? 20'h80000 : 20'h7ffff;
        return s[19:0];
    endfunction : sat
    task automatic chkReg(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chkReg
    task automatic chkMix(input string nm, input logic [19:0] e, input logic [19:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chkMix
    task automatic chkCnt(input string nm, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chkCnt
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] q);
        int n;
        @(posedge sys_clk);
        address <= {a, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {16'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0);
        chkCnt("bus answer", 2, n);
        q = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input string nm, input logic [15:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 16'h0, q);
        chkReg(nm, e, q);
    endtask : rdc
    task automatic waitIrq(input logic sel, output int t);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((sel ? resamplerIrq : offsetIrq) !== 1'b1 && n < 9000);
        chkCnt("irq seen", 1, int'(n < 9000));
        t = cyc;
    endtask : waitIrq
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst, read, write, address, writedata, byteenable} = {1'b1, 52'h0, 4'hf};
        {levelL, levelR, gap, num_errors, samples_checked, cyc, strobes} = '0;
        seed = 32'hff58bd45;
        idx = '{`IDX_OFFSET_MIX_CONFIG, `IDX_OFFSET_LEFT_LOW, `IDX_OFFSET_LEFT_HIGH,
            `IDX_OFFSET_RIGHT_LOW, `IDX_OFFSET_RIGHT_HIGH, `IDX_RESAMPLER_CONFIG,
            `IDX_RESAMPLER_LEFT_LOW, `IDX_RESAMPLER_LEFT_HIGH, `IDX_RESAMPLER_RIGHT_LOW,
            `IDX_RESAMPLER_RIGHT_HIGH};
        msk = '{16'h0, 16'hf000, 16'hffff, 16'hf000, 16'hffff, 16'h0, 16'hff00, 16'hffff,
            16'hff00, 16'hffff};
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rdc("reset value", idx[i], 16'h0);
        for (int i = 0; i < 10; i++) begin
            if (msk[i] != 16'h0) begin
                v = 16'(rnd());
                wr(idx[i], v);
                rdc("data readback", idx[i], v & msk[i]);
            end
        end
        byteenable <= 4'hc;
        wr(`IDX_RESAMPLER_RIGHT_HIGH, ~v);
        byteenable <= 4'hf;
        rdc("partial write", `IDX_RESAMPLER_RIGHT_HIGH, v);
        wr(16'hfec8, 16'h1234);
        rdc("unmapped", 16'hfec8, 16'h0);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            v = 16'(rnd());
            m = (k == 0) ? 20'h7f000 : (k == 1) ? 20'h81000 : {{3{v[16]}}, v[16:0]};
            v = 16'(rnd());
            o = (k == 0) ? 20'h02000 : (k == 1) ? 20'hfe000 : {{3{v[16]}}, v[16:0]};
            rate = (k == 0) ? 12'hfff : (k == 1) ? 12'h0 : 12'(rnd() & 32'h7);
            wr(`IDX_OFFSET_MIX_CONFIG, 16'h4000);
            levelL <= m;
            levelR <= ~m;
            wr(`IDX_OFFSET_LEFT_LOW, {o[3:0], 12'h0});
            wr(`IDX_OFFSET_LEFT_HIGH, o[19:4]);
            wr(`IDX_OFFSET_RIGHT_LOW, {~o[3:0], 12'h0});
            wr(`IDX_OFFSET_RIGHT_HIGH, ~o[19:4]);
            rdc("offset full", `IDX_OFFSET_MIX_CONFIG, 16'h2000);
            wr(`IDX_OFFSET_MIX_CONFIG, {4'h1, rate});
            waitIrq(1'b0, t0);
            waitIrq(1'b0, t1);
            chkCnt("offset interval", int'(rate) + 1, t1 - t0);
            chkMix("mix left", sat(m, o), mixLeft);
            chkMix("mix right", sat(~m, ~o), mixRight);
            wr(`IDX_OFFSET_MIX_CONFIG, 16'h0);
            rdc("offset underrun", `IDX_OFFSET_MIX_CONFIG, 16'h4000);
            repeat (2) @(posedge sys_clk);
            chkMix("mix bypass", m, mixLeft);
            $display("test offset case %0d done", k);
        end
        wr(`IDX_RESAMPLER_CONFIG, 16'h1003);
        strobes = 0;
        gap <= 8'h5;
        waitIrq(1'b1, t0);
        gap <= 8'h0;
        waitIrq(1'b1, t0);
        waitIrq(1'b1, t1);
        chkCnt("resampler interval", 8, t1 - t0);
        rdc("resampler flags", `IDX_RESAMPLER_CONFIG, 16'hf003);
        wr(`IDX_RESAMPLER_CONFIG, 16'h8000);
        rdc("left high", `IDX_RESAMPLER_LEFT_HIGH, dacLeft[23:8]);
        rdc("left low", `IDX_RESAMPLER_LEFT_LOW, {dacLeft[7:0], 8'h0});
        rdc("right high", `IDX_RESAMPLER_RIGHT_HIGH, dacRight[23:8]);
        rdc("right low", `IDX_RESAMPLER_RIGHT_LOW, {dacRight[7:0], 8'h0});
        rdc("flags cleared", `IDX_RESAMPLER_CONFIG, 16'h0);
        $display("test resampler done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
